// file: core/flpc_buf2.sv
`timescale 1ns/10ps
module flpc_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input  logic         clk_sys,
  input  logic         rst,
  // filling side
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // draining side
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] d0_ff;
  logic [W-1:0] d1_ff;
  logic [W-1:0] nxt_d0;
  logic [W-1:0] nxt_d1;
  logic         v0_ff;
  logic         v1_ff;
  logic         rdy_ff;
  logic         nxt_v0;
  logic         nxt_v1;
  wire          push = in_valid & rdy_ff;
  wire          pop  = v0_ff & out_ready;

  // head entry is always d0; a pop shifts d1 forward before any push lands
  always_comb
  begin
    nxt_d0 = d0_ff;
    nxt_d1 = d1_ff;
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    if (pop)
    begin
      nxt_d0 = d1_ff;
      nxt_v0 = v1_ff;
      nxt_v1 = 1'b0;
    end
    if (push && !nxt_v0)
    begin
      nxt_d0 = in_data;
      nxt_v0 = 1'b1;
    end
    else if (push)
    begin
      nxt_d1 = in_data;
      nxt_v1 = 1'b1;
    end
  end

  // storage and a registered ready that drops once both entries hold words
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      v0_ff  <= 1'b0;
      v1_ff  <= 1'b0;
      rdy_ff <= 1'b1;
      d0_ff  <= '0;
      d1_ff  <= '0;
    end
    else
    begin
      v0_ff  <= nxt_v0;
      v1_ff  <= nxt_v1;
      rdy_ff <= !nxt_v1;
      d0_ff  <= nxt_d0;
      d1_ff  <= nxt_d1;
    end
  end

  assign in_ready  = rdy_ff;
  assign out_valid = v0_ff;
  assign out_data  = d0_ff;
endmodule // flpc_buf2

// file: core/flpc_host.sv
`timescale 1ns/10ps
module flpc_host (
  // clock and reset
  input  logic                       clk_sys,
  input  logic                       rst,
  // user command port
  input  logic                       cmd_valid,
  output logic                       cmd_ready,
  input  flpc_pkg::flpc_cmd_t        cmd,
  // buffered-write data words
  input  logic                       wd_valid,
  output logic                       wd_ready,
  input  logic [flpc_pkg::DQ_W-1:0]  wd_data,
  // result of each command
  output logic                       res_valid,
  output flpc_pkg::flpc_res_t        res,
  // status pin report
  output logic                       sts_busy,
  output logic                       sts_rise,
  // flash pins
  output logic [flpc_pkg::ADDR_W-1:0] flash_addr,
  input  logic [flpc_pkg::DQ_W-1:0]  flash_dq_i,
  output logic [flpc_pkg::DQ_W-1:0]  flash_dq_o,
  output logic                       flash_dq_oe,
  output logic                       flash_ce_n,
  output logic                       flash_oe_n,
  output logic                       flash_we_n,
  output logic                       flash_rp_n,
  output logic                       flash_rp_hv,
  input  logic                       flash_sts
);
  import flpc_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WR   = 3'h1,
    S_RD   = 3'h2,
    S_STEP = 3'h3
  } flpc_state_t;
  typedef enum logic [2:0] {
    PH_SETUP = 3'h0,
    PH_XSR   = 3'h1,
    PH_DATA  = 3'h2,
    PH_CODE  = 3'h3,
    PH_LAST  = 3'h4,
    PH_POLL  = 3'h5
  } flpc_phase_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_WR   = 2'h1,
    ACT_RD   = 2'h2,
    ACT_FIN  = 2'h3
  } flpc_kind_t;
  typedef struct packed {
    flpc_kind_t          kind;
    logic [ADDR_W-1:0]   addr;
    logic [DQ_W-1:0]     data;
    flpc_phase_t         ph;
    logic                pop;
  } flpc_act_t;

  flpc_state_t         state_ff;
  flpc_state_t         nxt_state;
  flpc_phase_t         phase_ff;
  flpc_cmd_t           cur_ff;
  flpc_res_t           res_ff;
  flpc_act_t           act;
  logic [CNT_W-1:0]    idx_ff;
  logic [CYC_W-1:0]    cyc_ff;
  logic [CYC_W-1:0]    nxt_cyc;
  logic [7:0]          rdata_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [ADDR_W-1:0]   nxt_addr;
  logic [DQ_W-1:0]     dq_ff;
  logic [DQ_W-1:0]     nxt_dq;
  logic [DQ_W-1:0]     dq_s1_ff;
  logic [DQ_W-1:0]     dq_s2_ff;
  logic                dq_oe_ff;
  logic                nxt_dq_oe;
  logic                we_n_ff;
  logic                nxt_we_n;
  logic                oe_n_ff;
  logic                nxt_oe_n;
  logic                ce_n_ff;
  logic                nxt_ce_n;
  logic                cmd_ready_ff;
  logic                res_valid_ff;
  logic                err_sticky_ff;
  logic                rp_hv_ff;
  logic                sts_s1_ff;
  logic                sts_s2_ff;
  logic                sts_d_ff;
  logic                sts_busy_ff;
  logic                sts_rise_ff;
  logic                fifo_vld;
  logic [DQ_W-1:0]     fifo_data;

  // two-entry buffer between the user word stream and the flash bus
  flpc_buf2 #(.W(DQ_W)) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   (wd_data),
    .out_valid (fifo_vld),
    .out_ready (act.pop),
    .out_data  (fifo_data)
  );

  // first command byte of each operation
  function automatic logic [7:0] first_cmd(input flpc_op_t op);
    case (op)
      OP_PROG:  return CMD_PROG;
      OP_BUF:   return CMD_BUF_SETUP;
      OP_CFG:   return CMD_CFG;
      OP_LOCKB: return CMD_LOCK_SETUP;
      OP_LOCKM: return CMD_LOCK_SETUP;
      OP_CLR:   return CMD_CLR;
      default:  return CMD_RDSTAT;
    endcase
  endfunction

  // true when a buffered burst would leave its erase block or is empty
  function automatic logic blk_cross(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] n);
    logic [BLK_W:0] last;
    last = {1'b0, a[BLK_W-1:0]} + (BLK_W+1)'(n) - (BLK_W+1)'(1);
    return last[BLK_W] || (n == '0);
  endfunction

  // bus write action carrying a command byte
  function automatic flpc_act_t wr_cmd(input logic [ADDR_W-1:0] a, input logic [7:0] c,
                                       input flpc_phase_t p);
    return '{ACT_WR, a, DQ_W'(c), p, 1'b0};
  endfunction

  // refusals: sticky errors block work until cleared, bursts must fit one block
  wire op_free  = (cmd.op == OP_CLR) || (cmd.op == OP_RDST);
  wire refuse   = (err_sticky_ff && !op_free)
                  || (cmd.op == OP_BUF && blk_cross(cmd.addr, cmd.count));
  wire take     = (state_ff == S_IDLE) && cmd_valid && cmd_ready_ff;
  wire fin      = (state_ff == S_STEP) && (act.kind == ACT_FIN);
  wire res_err  = |(rdata_ff & ERR_MASK);
  wire at_end   = (idx_ff == cur_ff.count);
  wire [ADDR_W-1:0] word_addr = cur_ff.addr + ADDR_W'(idx_ff);

  // sequence decoder: picks the next bus cycle from operation and phase
  always_comb
  begin
    act = '{ACT_NONE, cur_ff.addr, '0, phase_ff, 1'b0};
    if (take && !refuse)
      act = wr_cmd(cmd.addr, first_cmd(cmd.op), PH_SETUP);
    else if (state_ff == S_STEP)
    begin
      case (phase_ff)
        PH_SETUP:
          case (cur_ff.op)
            OP_PROG:  act = '{ACT_WR, cur_ff.addr, cur_ff.data, PH_LAST, 1'b0};
            OP_BUF:   act = '{ACT_RD, cur_ff.addr, '0, PH_XSR, 1'b0};
            OP_CFG:   act = wr_cmd(cur_ff.addr, cur_ff.data[7:0] & CFG_MASK, PH_CODE);
            OP_LOCKB: act = wr_cmd(cur_ff.addr, CMD_LOCK_BLK, PH_LAST);
            OP_LOCKM: act = wr_cmd(cur_ff.addr, CMD_LOCK_MST, PH_LAST);
            OP_CLR:   act = wr_cmd(cur_ff.addr, CMD_RDSTAT, PH_LAST);
            default:  act = '{ACT_RD, cur_ff.addr, '0, PH_POLL, 1'b0};
          endcase
        PH_XSR:
          if (rdata_ff[XSR_AVAIL])
            act = '{ACT_WR, cur_ff.addr, DQ_W'(cur_ff.count), PH_DATA, 1'b0};
          else
            act = wr_cmd(cur_ff.addr, CMD_BUF_SETUP, PH_SETUP);
        PH_DATA:
          if (at_end)
            act = wr_cmd(cur_ff.addr, CMD_CONFIRM, PH_LAST);
          else if (fifo_vld)
            act = '{ACT_WR, word_addr, fifo_data, PH_DATA, 1'b1};
        PH_CODE:  act = wr_cmd(cur_ff.addr, CMD_RDSTAT, PH_LAST);
        PH_LAST:  act = '{ACT_RD, cur_ff.addr, '0, PH_POLL, 1'b0};
        PH_POLL:
          if (rdata_ff[SR_READY])
            act.kind = ACT_FIN;
          else
            act = '{ACT_RD, cur_ff.addr, '0, PH_POLL, 1'b0};
        default:  act.kind = ACT_FIN;
      endcase
    end
  end

  // bus cycle engine: strobe low for the write width, data held past its rise
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cyc   = cyc_ff - CYC_W'(1);
    nxt_addr  = addr_ff;
    nxt_dq    = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_we_n  = we_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_ce_n  = ce_n_ff;
    case (state_ff)
      S_WR:
      begin
        nxt_we_n = (cyc_ff == CYC_W'(1)) || we_n_ff;
        if (cyc_ff == '0)
        begin
          nxt_dq_oe = 1'b0;
          nxt_ce_n  = 1'b1;
          nxt_state = S_STEP;
        end
      end
      S_RD:
        if (cyc_ff == '0)
        begin
          nxt_oe_n  = 1'b1;
          nxt_ce_n  = 1'b1;
          nxt_state = S_STEP;
        end
      default:
        if (act.kind == ACT_WR)
        begin
          nxt_state = S_WR;
          nxt_cyc   = WE_CYC;
          nxt_addr  = act.addr;
          nxt_dq    = act.data;
          nxt_dq_oe = 1'b1;
          nxt_we_n  = 1'b0;
          nxt_ce_n  = 1'b0;
        end
        else if (act.kind == ACT_RD)
        begin
          nxt_state = S_RD;
          nxt_cyc   = RD_CYC;
          nxt_addr  = act.addr;
          nxt_oe_n  = 1'b0;
          nxt_ce_n  = 1'b0;
        end
        else if (act.kind == ACT_FIN)
          nxt_state = S_IDLE;
    endcase
  end

  // state, phase and pin registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= S_IDLE;
      phase_ff <= PH_SETUP;
      cyc_ff   <= '0;
      addr_ff  <= '0;
      dq_ff    <= '0;
      dq_oe_ff <= 1'b0;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      ce_n_ff  <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      phase_ff <= (act.kind == ACT_WR || act.kind == ACT_RD) ? act.ph : phase_ff;
      cyc_ff   <= nxt_cyc;
      addr_ff  <= nxt_addr;
      dq_ff    <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      we_n_ff  <= nxt_we_n;
      oe_n_ff  <= nxt_oe_n;
      ce_n_ff  <= nxt_ce_n;
    end
  end

  // command capture, word index, status read-back and result
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cur_ff        <= '0;
      idx_ff        <= '0;
      rdata_ff      <= '0;
      cmd_ready_ff  <= 1'b0;
      res_valid_ff  <= 1'b0;
      res_ff        <= '0;
      err_sticky_ff <= 1'b0;
      rp_hv_ff      <= 1'b0;
    end
    else
    begin
      cur_ff        <= (take && !refuse) ? cmd : cur_ff;
      idx_ff        <= (phase_ff == PH_XSR) ? '0 : idx_ff + CNT_W'(act.pop);
      rdata_ff      <= (state_ff == S_RD && cyc_ff == '0) ? dq_s2_ff[7:0] : rdata_ff;
      cmd_ready_ff  <= (nxt_state == S_IDLE);
      res_valid_ff  <= fin || (take && refuse);
      res_ff        <= fin ? flpc_res_t'{1'b0, res_err, rdata_ff} :
                       (take && refuse) ? flpc_res_t'{1'b1, 1'b0, 8'h00} : res_ff;
      err_sticky_ff <= (fin && res_err) ? 1'b1 :
                       (fin && cur_ff.op == OP_CLR) ? 1'b0 : err_sticky_ff;
      rp_hv_ff      <= (take && !refuse) ? cmd.hv : (fin ? 1'b0 : rp_hv_ff);
    end
  end

  // pin synchronisers and status pin level and release edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dq_s1_ff    <= '0;
      dq_s2_ff    <= '0;
      sts_s1_ff   <= 1'b1;
      sts_s2_ff   <= 1'b1;
      sts_d_ff    <= 1'b1;
      sts_busy_ff <= 1'b0;
      sts_rise_ff <= 1'b0;
    end
    else
    begin
      dq_s1_ff    <= flash_dq_i;
      dq_s2_ff    <= dq_s1_ff;
      sts_s1_ff   <= flash_sts;
      sts_s2_ff   <= sts_s1_ff;
      sts_d_ff    <= sts_s2_ff;
      sts_busy_ff <= !sts_s2_ff;
      sts_rise_ff <= sts_s2_ff && !sts_d_ff;
    end
  end

  assign cmd_ready   = cmd_ready_ff;
  assign res_valid   = res_valid_ff;
  assign res         = res_ff;
  assign sts_busy    = sts_busy_ff;
  assign sts_rise    = sts_rise_ff;
  assign flash_addr  = addr_ff;
  assign flash_dq_o  = dq_ff;
  assign flash_dq_oe = dq_oe_ff;
  assign flash_ce_n  = ce_n_ff;
  assign flash_oe_n  = oe_n_ff;
  assign flash_we_n  = we_n_ff;
  assign flash_rp_n  = 1'b1;
  assign flash_rp_hv = rp_hv_ff;

  // checks on the driven bus sequence
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_status_read;
    (state_ff == S_RD && !oe_n_ff)[*7] ##1 (state_ff == S_STEP);
  endsequence
  property p_we_width;
    $fell(we_n_ff) |-> !we_n_ff[*2] ##1 we_n_ff;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
  property p_data_hold;
    $rose(we_n_ff) |-> dq_oe_ff && $stable(dq_ff) && !ce_n_ff;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");
  property p_prog_setup;
    (take && !refuse && cmd.op == OP_PROG) |=> !we_n_ff && dq_ff == DQ_W'(CMD_PROG);
  endproperty
  a_prog_setup: assert property (p_prog_setup) else $error("program setup not written");
  property p_xsr_retry;
    (state_ff == S_STEP && phase_ff == PH_XSR && !rdata_ff[XSR_AVAIL])
      |=> state_ff == S_WR && dq_ff == DQ_W'(CMD_BUF_SETUP);
  endproperty
  a_xsr_retry: assert property (p_xsr_retry) else $error("buffer setup not retried");
  property p_in_range;
    ($fell(we_n_ff) && phase_ff == PH_DATA) |-> (addr_ff - cur_ff.addr) < ADDR_W'(cur_ff.count);
  endproperty
  a_in_range: assert property (p_in_range) else $error("buffer address out of range");
  property p_confirm;
    (state_ff == S_STEP && phase_ff == PH_DATA && at_end)
      |=> dq_ff == DQ_W'(CMD_CONFIRM) && !we_n_ff;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm missing after last word");
  property p_cfg_code;
    (state_ff == S_STEP && phase_ff == PH_SETUP && cur_ff.op == OP_CFG)
      |=> dq_ff == DQ_W'(cur_ff.data[7:0] & CFG_MASK);
  endproperty
  a_cfg_code: assert property (p_cfg_code) else $error("configuration code not written");
  property p_master_conf;
    (state_ff == S_STEP && phase_ff == PH_SETUP && cur_ff.op == OP_LOCKM)
      |=> dq_ff == DQ_W'(CMD_LOCK_MST);
  endproperty
  a_master_conf: assert property (p_master_conf) else $error("master confirm not written");
  property p_poll;
    (state_ff == S_STEP && phase_ff == PH_POLL && !rdata_ff[SR_READY]) |=> s_status_read;
  endproperty
  a_poll: assert property (p_poll) else $error("status poll not repeated");
  property p_refuse;
    (take && err_sticky_ff && cmd.op == OP_PROG) |=> res_valid_ff && res_ff.refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("program taken with sticky error");
endmodule // flpc_host

// file: shared/flpc_pkg.sv
package flpc_pkg;
  // widths of the flash pins and of the user command
  localparam int ADDR_W = 23;
  localparam int DQ_W   = 16;
  localparam int CNT_W  = 6;
  localparam int BLK_W  = 17;
  localparam int CYC_W  = 4;

  // command bytes written on the low data lane
  localparam logic [7:0] CMD_PROG       = 8'h40;
  localparam logic [7:0] CMD_CLR        = 8'h50;
  localparam logic [7:0] CMD_CFG        = 8'hB8;
  localparam logic [7:0] CMD_RDSTAT     = 8'h70;
  localparam logic [7:0] CMD_BUF_SETUP  = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLK   = 8'h01;
  localparam logic [7:0] CMD_LOCK_MST   = 8'hF1;
  localparam logic [7:0] CFG_MASK       = 8'h03;

  // status byte layout
  localparam int         SR_READY  = 7;
  localparam int         XSR_AVAIL = 7;
  localparam logic [7:0] ERR_MASK  = 8'h3A;

  // bus timing at the 40 MHz system clock
  localparam int CLK_NS   = 25;
  localparam int T_WE_NS  = 50;
  localparam int T_RD_NS  = 100;
  localparam int SYNC_CYC = 2;
  localparam logic [CYC_W-1:0] WE_CYC = CYC_W'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] RD_CYC = CYC_W'((T_RD_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);

  // operations the user may order
  typedef enum logic [2:0] {
    OP_PROG  = 3'h0,
    OP_BUF   = 3'h1,
    OP_CFG   = 3'h2,
    OP_LOCKB = 3'h3,
    OP_LOCKM = 3'h4,
    OP_CLR   = 3'h5,
    OP_RDST  = 3'h6
  } flpc_op_t;

  typedef struct packed {
    flpc_op_t            op;
    logic                hv;
    logic [ADDR_W-1:0]   addr;
    logic [DQ_W-1:0]     data;
    logic [CNT_W-1:0]    count;
  } flpc_cmd_t;

  typedef struct packed {
    logic                refused;
    logic                error;
    logic [7:0]          status;
  } flpc_res_t;
endpackage

// file: tb/flpc_flash_model.sv
`timescale 1ns/10ps
module flpc_flash_model (
  // clock and supply condition
  input  logic                        clk_sys,
  input  logic                        lk,
  // flash pins
  input  logic [flpc_pkg::ADDR_W-1:0] flash_addr,
  input  logic [flpc_pkg::DQ_W-1:0]   flash_dq_o,
  input  logic                        flash_ce_n,
  input  logic                        flash_oe_n,
  input  logic                        flash_we_n,
  input  logic                        flash_rp_hv,
  output logic [flpc_pkg::DQ_W-1:0]   flash_dq_i,
  output logic                        flash_sts
);
  import flpc_pkg::*;
  // device state
  logic [7:0]  sr = 8'h00, cfg = 8'h00, d;
  logic [2:0]  st = 3'h0;
  logic [5:0]  n, busy = 6'h00, pw = 6'h00;
  logic [63:0] blk = 64'h0;
  // first buffer setup reports the buffer taken, so the host must retry once
  logic        mlk = 1'b0, xav = 1'b1, xm = 1'b0, we_q = 1'b1;
  logic [22:0] ba;
  logic [15:0] last = 16'h0000, wr_a, wr_d;
  // start a program unless lockout or lock bit forbids it, sampled at the data write of a word program or at confirm
  task automatic prog();
    if (lk) sr = sr | 8'h18;
    else if (blk[ba[22:17]] && !flash_rp_hv) sr = sr | 8'h12;
    else busy = 6'h08;
  endtask
  // command decoding on the write strobe rise, engine timing; falling edge keeps
  // the model's outputs away from the host's sampling edge
  always @(negedge clk_sys)
  begin
    d = flash_dq_o[7:0];
    if (busy == 6'h01 && cfg[1]) pw = 6'h0A;
    if (busy != 0) busy = busy - 1;
    else if (pw != 0) pw = pw - 1;
    if (flash_we_n && !we_q && !flash_ce_n)
    begin
      case (st)
        3'h0:
        begin
          xm = 1'b0;
          if (d == CMD_PROG) st = 3'h1;
          if (d == CMD_BUF_SETUP && !(sr[5] | sr[4]))
          begin
            xm = 1'b1;
            xav = ~xav;
            st = {1'b0, xav, 1'b0};
          end
          if (d == CMD_LOCK_SETUP) st = 3'h4;
          if (d == CMD_CFG) st = 3'h5;
          if (d == CMD_CLR) sr = 8'h00;
        end
        3'h1:
        begin
          ba = flash_addr;
          wr_a = flash_addr[15:0];
          wr_d = flash_dq_o;
          prog();
          st = 3'h0;
        end
        3'h2:
        begin
          ba = flash_addr;
          n = d[5:0];
          xm = 1'b0;  // later reads return the status byte
          st = 3'h3;
        end
        3'h3:
        begin
          if (flash_addr[22:17] != ba[22:17]) sr = sr | 8'h30;
          wr_a = flash_addr[15:0];
          wr_d = flash_dq_o;
          n = n - 1;
          if (n == 0) st = 3'h6;
        end
        3'h6:
        begin
          if (d == CMD_CONFIRM) prog();
          else sr = sr | 8'h30;
          st = 3'h0;
        end
        3'h4:
        begin
          if (busy != 0 || !(d == CMD_LOCK_BLK || d == CMD_LOCK_MST))
            sr = sr | 8'h30;
          else if (lk) sr = sr | 8'h08;
          else if (d == CMD_LOCK_MST && !flash_rp_hv) sr = sr | 8'h12;
          else if (d == CMD_LOCK_BLK && mlk && !flash_rp_hv) sr = sr | 8'h12;
          else if (d == CMD_LOCK_MST) mlk = 1'b1;
          else blk[flash_addr[22:17]] = 1'b1;
          st = 3'h0;
        end
        3'h5:
        begin
          if (d > 8'h03) sr = sr | 8'h30;
          else cfg = d;
          st = 3'h0;
        end
        default: st = 3'h0;
      endcase
    end
    we_q = flash_we_n;
    last = flash_dq_i;
  end
  // status reads; low bits are noise while busy, bus toggles when released
  assign flash_dq_i = (!flash_oe_n && !flash_ce_n) ? {8'h00, xm ? {xav, 7'h00} :
                      (busy != 0) ? {1'b0, ~sr[6:0]} : {1'b1, sr[6:0]}} : ~last;
  assign flash_sts  = (cfg[1:0] == 2'h0) ? (busy == 0) : (pw == 0);
endmodule // flpc_flash_model

// file: tb/flpc_host_bench.sv
`timescale 1ns/10ps
module flpc_host_bench;
  import flpc_pkg::*;
  typedef struct packed {
    flpc_op_t          op;
    logic              hv;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
    logic [5:0]        cnt;
    logic [7:0]        st;
  } flpc_row_t;
  // stimulus and observed signals
  logic              clk_sys = 1'b0, rst = 1'b0, cmd_valid = 1'b0, wd_valid = 1'b0, lk = 1'b0;
  logic [15:0]       wd_data = 16'h0000;
  flpc_cmd_t         cmd = '0;
  flpc_res_t         res;
  logic              cmd_ready, wd_ready, res_valid, sts_busy, sts_rise, flash_sts;
  logic              flash_ce_n, flash_oe_n, flash_we_n, flash_rp_hv, flash_dq_oe, flash_rp_n;
  logic [ADDR_W-1:0] flash_addr;
  logic [DQ_W-1:0]   flash_dq_i, flash_dq_o;
  int                n_errors = 0, check_count = 0, cyc = 0, rises = 0, r0, busies = 0, b0;
  // ordinary cases; status 00h marks a refused command
  flpc_row_t rows [20] = '{
    '{OP_PROG, 1'h0, 23'h10, 16'h1234, 6'h0, 8'h80}, '{OP_CFG, 1'h0, 23'h0, 16'h2, 6'h0, 8'h80},
    '{OP_PROG, 1'h0, 23'h20, 16'h5A5A, 6'h0, 8'h80}, '{OP_CFG, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80},
    '{OP_LOCKB, 1'h0, 23'h20000, 16'h0, 6'h0, 8'h80},
    '{OP_PROG, 1'h0, 23'h20004, 16'h0F0F, 6'h0, 8'h92},
    '{OP_PROG, 1'h0, 23'h0, 16'h0, 6'h0, 8'h00}, '{OP_CLR, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80},
    '{OP_PROG, 1'h1, 23'h20004, 16'h0F0F, 6'h0, 8'h80},
    '{OP_LOCKM, 1'h0, 23'h0, 16'h0, 6'h0, 8'h92}, '{OP_CLR, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80},
    '{OP_LOCKM, 1'h1, 23'h0, 16'h0, 6'h0, 8'h80},
    '{OP_LOCKB, 1'h0, 23'h40000, 16'h0, 6'h0, 8'h92}, '{OP_CLR, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80},
    '{OP_BUF, 1'h0, 23'h100, 16'h0, 6'h2, 8'h80}, '{OP_BUF, 1'h0, 23'h100, 16'h0, 6'h0, 8'h00},
    '{OP_BUF, 1'h0, 23'h1FFFF, 16'h0, 6'h2, 8'h00},
    '{OP_PROG, 1'h0, 23'h30, 16'h1111, 6'h0, 8'h98},
    '{OP_CLR, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80}, '{OP_RDST, 1'h0, 23'h0, 16'h0, 6'h0, 8'h80}};
  flpc_host dut (.clk_sys, .rst, .cmd_valid, .cmd_ready, .cmd, .wd_valid, .wd_ready, .wd_data,
    .res_valid, .res, .sts_busy, .sts_rise, .flash_addr, .flash_dq_i, .flash_dq_o, .flash_dq_oe,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rp_n, .flash_rp_hv, .flash_sts);
  flpc_flash_model fm (.clk_sys, .lk, .flash_addr, .flash_dq_o, .flash_ce_n, .flash_oe_n,
    .flash_we_n, .flash_rp_hv, .flash_dq_i, .flash_sts);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // offer words to the buffer, holding each until it is taken
  task automatic feed(input int n);
    for (int i = 0; i < n; i++)
    begin
      while (!wd_ready) @(negedge clk_sys);
      wd_valid = 1'b1;
      wd_data = 16'h1230 + 16'(i);
      @(negedge clk_sys);
    end
    wd_valid = 1'b0;
  endtask
  task automatic run(input flpc_row_t r);
    while (!cmd_ready) @(negedge clk_sys);
    lk = r.st[3];
    cmd = '{r.op, r.hv, r.addr, r.data, r.cnt};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (!res_valid) @(negedge clk_sys);
  endtask
  // clock, run limit and status pin rises
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (sts_rise === 1'b1) rises++;
    if (sts_busy === 1'b1) busies++;
    if (cyc == 40000)
    begin
      n_errors++;
      complete_run;
    end
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("ready", 32'h0, cmd_ready);
    rst = 1'b0;
    foreach (rows[i])
    begin
      r0 = rises;
      b0 = busies;
      if (rows[i].op == OP_BUF && rows[i].st != 0)
        fork feed(3); run(rows[i]); join
      else
        run(rows[i]);
      chk("refused", rows[i].st == 8'h00, res.refused);
      if (rows[i].st != 0) chk("status", rows[i].st, res.status);
      if (rows[i].st != 0) chk("error", |(rows[i].st & ERR_MASK), res.error);
      if (i == 0 || i == 2)
      begin
        // the pin report trails the pin, so let the pulse pass first
        repeat (8) @(negedge clk_sys);
        chk("rises", 32'h1, rises - r0);
        chk("low", (i == 0) ? 32'h8 : 32'hA, busies - b0);
      end
      if (i == 0) chk("word", 32'h00101234, {fm.wr_a, fm.wr_d});
      if (i == 14) chk("burst", 32'h01011231, {fm.wr_a, fm.wr_d});
    end
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    chk("reset", 32'h5, {cmd_ready, res_valid, flash_we_n, flash_dq_oe, flash_rp_n});
    rst = 1'b0;
    @(negedge clk_sys);
    chk("ready", 32'h1, cmd_ready);
    complete_run;
  end
endmodule // flpc_host_bench
